// >>> rtl/occ_defines.svh
// Purpose: constants for the group offset code control block
// Assumes: 12-bit codes, 25 MHz logic clock
// Notes:   register indices are word addresses on the plain register port
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

`define OCC_CODE_W          12
`define OCC_ADDR_W          4
`define OCC_DATA_W          16
// register indices
`define OCC_ADDR_CONFIG     4'h0
`define OCC_ADDR_CODE_A     4'h1
`define OCC_ADDR_CODE_B     4'h2
`define OCC_ADDR_STATUS     4'h3
// configuration fields
`define OCC_CFG_GAIN_BIT    0
`define OCC_CFG_RESET       1'h0
// straight binary defaults, gain six and gain four
`define OCC_DEF_GAIN6       12'h99a
`define OCC_DEF_GAIN4       12'haab
// twos complement form differs by the msb
`define OCC_FMT_FLIP        12'h800
`define OCC_CODE_ZERO       12'h000

`endif

// >>> rtl/occ_pkg.sv
// Purpose: types for the group offset code control block
// Assumes: nothing
// Notes:   none
package occ_pkg;
    typedef enum logic {
        OCC_GAIN4,
        OCC_GAIN6
    } occ_gain_type;

    typedef enum logic [1:0] {
        OCC_ST_RESET,
        OCC_ST_RUN,
        OCC_ST_RELOAD
    } occ_state_type;
endpackage : occ_pkg

// >>> rtl/occ_code_if.sv
// Purpose: carries one group code and its controls between modules
// Assumes: one clock
// Notes:   none
`timescale 1ns/100ps
`include "occ_defines.svh"
interface occ_code_if;
    logic                   load_default;
    logic                   write_en;
    logic [`OCC_CODE_W-1:0] write_data;
    logic [`OCC_CODE_W-1:0] default_code;
    logic [`OCC_CODE_W-1:0] code;
    logic [`OCC_CODE_W-1:0] code_binary;

    modport ctrl (output load_default, write_en, write_data, default_code,
                  input code, code_binary);
    modport store (input load_default, write_en, write_data, default_code,
                   output code, code_binary);
endinterface : occ_code_if

// >>> rtl/occ_group_code.sv
// Purpose: holds one group's offset code
// Assumes: default code already in the written format
// Notes:   a default load wins over a host write in the same cycle
`timescale 1ns/100ps
`include "occ_defines.svh"
module occ_group_code (
    // clock and reset
    input  wire logic clock_i,
    input  wire logic nrst_i,
    // format
    input  wire logic twos_fmt_i,
    // code port
    occ_code_if.store cif
);
    logic [`OCC_CODE_W-1:0] code_r;

    function automatic logic [`OCC_CODE_W-1:0] to_binary(input logic [`OCC_CODE_W-1:0] c,
                                                       input logic tc);
        to_binary = tc ? (c ^ `OCC_FMT_FLIP) : c;
    endfunction : to_binary

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            code_r <= `OCC_CODE_ZERO;
        end else if (cif.load_default) begin
            code_r <= cif.default_code;
        end else if (cif.write_en) begin
            code_r <= cif.write_data;
        end
    end

    assign cif.code        = code_r;
    assign cif.code_binary = to_binary(code_r, twos_fmt_i);
endmodule : occ_group_code

// >>> rtl/occ_power_gate.sv
// Purpose: gates the offset converter drive in single-supply operation
// Assumes: supply mode is a static strap
// Notes:   output amplifier enable low means high impedance
`timescale 1ns/100ps
`include "occ_defines.svh"
module occ_power_gate (
    // clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   nrst_i,
    // control
    input  wire logic                   single_supply_i,
    input  wire logic [`OCC_CODE_W-1:0] code_i,
    // converter drive
    output logic                        power_on_o,
    output logic                        amp_en_o,
    output logic [`OCC_CODE_W-1:0]      drive_code_o
);
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            power_on_o   <= 1'b0;
            amp_en_o     <= 1'b0;
            drive_code_o <= `OCC_CODE_ZERO;
        end else begin
            power_on_o   <= !single_supply_i;
            amp_en_o     <= !single_supply_i;
            drive_code_o <= single_supply_i ? `OCC_CODE_ZERO : code_i;
        end
    end
endmodule : occ_power_gate

// >>> rtl/occ_offset_code_control.sv
// Purpose: control of the two group offset codes of an eight-channel converter
// Assumes: register port and straps synchronous to clock_i
// Notes:   drive codes to the converters are always straight binary
//
// Overview of operation
// - two independent 12-bit codes, one per four-channel group
// - larger code drives the group outputs more negative
// - zero channel code output is -vref*(gain-1)*code/4096
// - after reset each code loads the default for format and range
// - a gain change reloads each code with the new gain default
// - single supply powers converters off, amplifiers high impedance
// - symmetric bipolar defaults 99ah gain six, aabh gain four
// - trimmed defaults 2458 and 2731, per group, may differ one step
// - format pin high twos complement, low straight binary
// - gain comes from the configuration gain bit
// - read back returns the code in the written format
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "occ_defines.svh"
module occ_offset_code_control #(
    parameter logic [`OCC_CODE_W-1:0] TRIM_A_GAIN6 = `OCC_DEF_GAIN6,
    parameter logic [`OCC_CODE_W-1:0] TRIM_A_GAIN4 = `OCC_DEF_GAIN4,
    parameter logic [`OCC_CODE_W-1:0] TRIM_B_GAIN6 = `OCC_DEF_GAIN6,
    parameter logic [`OCC_CODE_W-1:0] TRIM_B_GAIN4 = `OCC_DEF_GAIN4
) (
    // clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   nrst_i,
    // straps
    input  wire logic                   number_format_select_pin_i,
    input  wire logic                   single_supply_i,
    // register port
    input  wire logic [`OCC_ADDR_W-1:0] reg_addr_i,
    input  wire logic [`OCC_DATA_W-1:0] reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [`OCC_DATA_W-1:0] reg_rdata_o,
    // offset converter drive, group a
    output logic      [`OCC_CODE_W-1:0] offset_code_a_o,
    output logic                        offset_power_a_o,
    output logic                        offset_amp_en_a_o,
    // offset converter drive, group b
    output logic      [`OCC_CODE_W-1:0] offset_code_b_o,
    output logic                        offset_power_b_o,
    output logic                        offset_amp_en_b_o,
    // selected gain
    output logic                        gain_six_o
);
    occ_pkg::occ_state_type state_r;
    occ_pkg::occ_state_type state_nxt;
    logic                   gain_r;
    logic                   gain_nxt;
    logic                   twos_r;
    logic                   load_default;
    logic                   wr_cfg;

    occ_code_if cif_a ();
    occ_code_if cif_b ();

    // default in the written format
    function automatic logic [`OCC_CODE_W-1:0] fmt_default(input logic [`OCC_CODE_W-1:0] g6,
                                                         input logic [`OCC_CODE_W-1:0] g4,
                                                         input logic gain6,
                                                         input logic tc);
        logic [`OCC_CODE_W-1:0] b;
        b = gain6 ? g6 : g4;
        fmt_default = tc ? (b ^ `OCC_FMT_FLIP) : b;
    endfunction : fmt_default

    assign wr_cfg   = reg_wr_i && (reg_addr_i == `OCC_ADDR_CONFIG);
    assign gain_nxt = wr_cfg ? reg_wdata_i[`OCC_CFG_GAIN_BIT] : gain_r;

    // format strap caught after reset release and held
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            twos_r <= 1'b0;
        end else if (state_r == occ_pkg::OCC_ST_RESET) begin
            twos_r <= number_format_select_pin_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            gain_r <= `OCC_CFG_RESET;
        end else begin
            gain_r <= gain_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            occ_pkg::OCC_ST_RESET: begin
                state_nxt = occ_pkg::OCC_ST_RELOAD;
            end
            occ_pkg::OCC_ST_RUN: begin
                if (gain_nxt != gain_r) begin
                    state_nxt = occ_pkg::OCC_ST_RELOAD;
                end
            end
            occ_pkg::OCC_ST_RELOAD: begin
                state_nxt = (gain_nxt != gain_r) ? occ_pkg::OCC_ST_RELOAD
                                                 : occ_pkg::OCC_ST_RUN;
            end
            default: begin
                state_nxt = occ_pkg::OCC_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            state_r <= occ_pkg::OCC_ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign load_default = (state_r == occ_pkg::OCC_ST_RELOAD);

    // group a controls
    assign cif_a.load_default = load_default;
    assign cif_a.write_en     = reg_wr_i && (reg_addr_i == `OCC_ADDR_CODE_A);
    assign cif_a.write_data   = reg_wdata_i[`OCC_CODE_W-1:0];
    assign cif_a.default_code = fmt_default(TRIM_A_GAIN6, TRIM_A_GAIN4, gain_r, twos_r);

    // group b controls
    assign cif_b.load_default = load_default;
    assign cif_b.write_en     = reg_wr_i && (reg_addr_i == `OCC_ADDR_CODE_B);
    assign cif_b.write_data   = reg_wdata_i[`OCC_CODE_W-1:0];
    assign cif_b.default_code = fmt_default(TRIM_B_GAIN6, TRIM_B_GAIN4, gain_r, twos_r);

    occ_group_code u_code_a (
        .clock_i    (clock_i),
        .nrst_i     (nrst_i),
        .twos_fmt_i (twos_r),
        .cif        (cif_a)
    );

    occ_group_code u_code_b (
        .clock_i    (clock_i),
        .nrst_i     (nrst_i),
        .twos_fmt_i (twos_r),
        .cif        (cif_b)
    );

    // straight binary code to the converter; higher code, more negative output
    occ_power_gate u_gate_a (
        .clock_i         (clock_i),
        .nrst_i          (nrst_i),
        .single_supply_i (single_supply_i),
        .code_i          (cif_a.code_binary),
        .power_on_o      (offset_power_a_o),
        .amp_en_o        (offset_amp_en_a_o),
        .drive_code_o    (offset_code_a_o)
    );

    occ_power_gate u_gate_b (
        .clock_i         (clock_i),
        .nrst_i          (nrst_i),
        .single_supply_i (single_supply_i),
        .code_i          (cif_b.code_binary),
        .power_on_o      (offset_power_b_o),
        .amp_en_o        (offset_amp_en_b_o),
        .drive_code_o    (offset_code_b_o)
    );

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `OCC_ADDR_CONFIG: reg_rdata_o <= {{(`OCC_DATA_W-1){1'b0}}, gain_r};
                `OCC_ADDR_CODE_A: reg_rdata_o <= {4'h0, cif_a.code};
                `OCC_ADDR_CODE_B: reg_rdata_o <= {4'h0, cif_b.code};
                `OCC_ADDR_STATUS: reg_rdata_o <= {13'h0000, load_default, single_supply_i,
                                                  twos_r};
                default:          reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    assign gain_six_o = gain_r;
endmodule : occ_offset_code_control

// >>> verification/occ_offset_code_control_chk.sv
// Purpose: port assertions for the group offset code control
// Assumes: straps static while out of reset
// Notes:   none
`timescale 1ns/100ps
module occ_offset_code_control_chk #(
    parameter logic [11:0] TRIM_A_GAIN6 = 12'h99a,
    parameter logic [11:0] TRIM_A_GAIN4 = 12'haab,
    parameter logic [11:0] TRIM_B_GAIN6 = 12'h99a,
    parameter logic [11:0] TRIM_B_GAIN4 = 12'haab
) (
    // clock, reset, straps
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        number_format_select_pin_i,
    input wire logic        single_supply_i,
    // register port
    input wire logic [3:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // converter drive
    input wire logic [11:0] offset_code_a_o,
    input wire logic        offset_power_a_o,
    input wire logic        offset_amp_en_a_o,
    input wire logic [11:0] offset_code_b_o,
    input wire logic        offset_power_b_o,
    input wire logic        offset_amp_en_b_o,
    input wire logic        gain_six_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    idle_rdata_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
        else $error("read data not zero outside read cycle");
    pwr_off_a: assert property (single_supply_i && $past(single_supply_i) |->
        !(offset_power_a_o | offset_power_b_o | offset_amp_en_a_o | offset_amp_en_b_o)
        && offset_code_a_o == 12'h0 && offset_code_b_o == 12'h0)
        else $error("offset drive active in single supply");
    reload_six_a: assert property ($rose(gain_six_o) && !single_supply_i |->
        ##[1:3] offset_code_a_o == TRIM_A_GAIN6 && offset_code_b_o == TRIM_B_GAIN6)
        else $error("gain six default not reloaded");
    reload_four_a: assert property ($fell(gain_six_o) && !single_supply_i |->
        ##[1:3] offset_code_a_o == TRIM_A_GAIN4 && offset_code_b_o == TRIM_B_GAIN4)
        else $error("gain four default not reloaded");
    wr_drive_a: assert property (reg_wr_i && reg_addr_i == 4'h1 && $past(nrst_i, 3)
        && !single_supply_i && $stable(gain_six_o)
        |-> ##2 offset_code_a_o == ($past(reg_wdata_i[11:0], 2)
        ^ (number_format_select_pin_i ? 12'h800 : 12'h000)))
        else $error("group a drive does not follow write");
    wr_isolate_a: assert property (reg_wr_i && reg_addr_i == 4'h1 && $past(nrst_i, 3)
        |-> ##2 $stable(offset_code_b_o))
        else $error("group b drive moved on group a write");
    status_rd_a: assert property (reg_rd_i && reg_addr_i == 4'h3 && $past(nrst_i)
        |=> reg_rdata_o[15:3] == 13'h0
        && reg_rdata_o[1:0] == {single_supply_i, number_format_select_pin_i})
        else $error("status read wrong");
    unmapped_rd_a: assert property (reg_rd_i && reg_addr_i > 4'h3
        |=> reg_rdata_o == 16'h0)
        else $error("unmapped read not zero");
endmodule : occ_offset_code_control_chk

// >>> verification/occ_host_model.sv
// Purpose: host that writes and reads the offset code registers
// Assumes: one strobe per call, address and data scrambled when idle
// Notes:   none
`timescale 1ns/100ps
module occ_host_model (
    input  wire logic   clock_i,
    output logic [3:0]  reg_addr_o,
    output logic [15:0] reg_wdata_o,
    output logic        reg_wr_o,
    output logic        reg_rd_o
);
    initial begin
        reg_addr_o = 4'h0;
        reg_wdata_o = 16'h0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    task automatic access(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= w;
        reg_rd_o    <= !w;
        @(posedge clock_i);
        reg_wr_o    <= 1'b0;
        reg_rd_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask : access
endmodule : occ_host_model

// >>> verification/occ_offset_code_control_tb.sv
// Purpose: self-checking bench for the group offset code control
// Assumes: default trims
// Notes:   reads are scored by a watcher against a queue
`timescale 1ns/100ps
module occ_offset_code_control_tb;
    logic        clock_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        fmt = 1'b0;
    logic        single = 1'b0;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, v;
    logic        wr, rd, pwr_a, amp_a, pwr_b, amp_b, gain6;
    logic [11:0] code_a, code_b;
    logic        rd_q = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] seed = 16'h000f;
    int          fail_count = 0;
    int          tests_run = 0;
    always #20 clock_i = ~clock_i;
    occ_host_model i_occ_host_model (.clock_i(clock_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    occ_offset_code_control i_occ_offset_code_control (.clock_i(clock_i), .nrst_i(nrst_i),
        .number_format_select_pin_i(fmt), .single_supply_i(single), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .offset_code_a_o(code_a), .offset_power_a_o(pwr_a), .offset_amp_en_a_o(amp_a),
        .offset_code_b_o(code_b), .offset_power_b_o(pwr_b), .offset_amp_en_b_o(amp_b),
        .gain_six_o(gain6));
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction : xs
    // zero channel code output in units of vref/4096: -(gain-1)*code
    function automatic logic [15:0] volts(input logic [11:0] c, input logic g6);
        return 16'(-((g6 ? 5 : 3) * int'(c)));
    endfunction : volts
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic rx(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_occ_host_model.access(1'b0, a, 16'h0);
    endtask : rx
    task automatic restart(input logic f, input logic s);
        nrst_i <= 1'b0;
        fmt    <= f;
        single <= s;
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
    endtask : restart
    always @(posedge clock_i) rd_q <= rd;
    always @(negedge clock_i) begin
        if (rd_q && exp_q.size() > 0) check(rdata, exp_q.pop_front());
    end
    initial begin
        for (int f = 0; f < 2; f++) begin
            restart(f[0], 1'b0);
            rx(4'h1, f ? 16'h02ab : 16'h0aab);
            rx(4'h2, f ? 16'h02ab : 16'h0aab);
            rx(4'h3, 16'(f));
            rx(4'h7, 16'h0000);
            v = xs();
            i_occ_host_model.access(1'b1, 4'h1, v);
            i_occ_host_model.access(1'b1, 4'h2, ~v);
            rx(4'h1, v & 16'h0fff);
            rx(4'h2, ~v & 16'h0fff);
            @(negedge clock_i);
            check({4'h0, code_a}, (v & 16'h0fff) ^ (f ? 16'h0800 : 16'h0));
            check({4'h0, code_b}, (~v & 16'h0fff) ^ (f ? 16'h0800 : 16'h0));
            check(volts(code_a, gain6), volts(v[11:0] ^ {f[0], 11'h0}, 1'b0));
            check({12'h0, pwr_a, amp_a, pwr_b, amp_b}, 16'h000f);
            i_occ_host_model.access(1'b1, 4'h0, 16'h0001);
            repeat (4) @(posedge clock_i);
            rx(4'h2, f ? 16'h019a : 16'h099a);
            rx(4'h0, 16'h0001);
            @(negedge clock_i);
            check({15'h0, gain6}, 16'h0001);
            check({4'h0, code_a}, 16'h099a);
            check({4'h0, code_b}, 16'h099a);
            i_occ_host_model.access(1'b1, 4'h0, 16'h0000);
            repeat (4) @(posedge clock_i);
            rx(4'h1, f ? 16'h02ab : 16'h0aab);
            $display("defaults, writes and gain reload done, format %0d", f);
        end
        restart(1'b0, 1'b1);
        i_occ_host_model.access(1'b1, 4'h1, 16'h0123);
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        check({4'h0, code_a}, 16'h0000);
        check({4'h0, code_b}, 16'h0000);
        check({12'h0, pwr_a, amp_a, pwr_b, amp_b}, 16'h0000);
        $display("single supply done");
        for (int i = 0; i < 8 && exp_q.size() > 0; i++) @(posedge clock_i);
        if (exp_q.size() > 0) fail_count++;
        conclude();
    end
    initial begin
        repeat (3000) @(posedge clock_i);
        fail_count++;
        conclude();
    end
endmodule : occ_offset_code_control_tb
bind occ_offset_code_control occ_offset_code_control_chk #(.TRIM_A_GAIN6(TRIM_A_GAIN6),
    .TRIM_A_GAIN4(TRIM_A_GAIN4), .TRIM_B_GAIN6(TRIM_B_GAIN6), .TRIM_B_GAIN4(TRIM_B_GAIN4)
) i_occ_offset_code_control_chk (.clock_i(clock_i), .nrst_i(nrst_i),
    .number_format_select_pin_i(number_format_select_pin_i), .single_supply_i(single_supply_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .offset_code_a_o(offset_code_a_o),
    .offset_power_a_o(offset_power_a_o), .offset_amp_en_a_o(offset_amp_en_a_o),
    .offset_code_b_o(offset_code_b_o), .offset_power_b_o(offset_power_b_o),
    .offset_amp_en_b_o(offset_amp_en_b_o), .gain_six_o(gain_six_o));
